// ---- msd_pkg.sv ----
// Shared constants, types and helpers for the packet data scrambler and buffer.
// Assumes a single 125 MHz clock domain and an APB register bus with 8-bit addresses.
package msd_pkg;
    // Register byte offsets, one 32-bit word each
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_TXDATA0 = 8'h0c;
    localparam logic [7:0] REG_TXDATA1 = 8'h10;
    localparam logic [7:0] REG_RXDATA0 = 8'h14;
    localparam logic [7:0] REG_RXDATA1 = 8'h18;
    localparam logic [7:0] REG_RXHEAD = 8'h1c;
    localparam logic [7:0] REG_SEED_WORD_FIRST = 8'h20;
    localparam logic [7:0] REG_SEED_WORD_LAST = 8'h2c;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // Modem control field positions
    localparam int CTRL_SCR_LSB = 0;
    localparam int CTRL_RAW_BIT = 2;
    localparam int CTRL_FMT_LSB = 3;
    localparam int CTRL_SELCALL_BIT = 11;
    localparam int CTRL_W = 12;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

    // Status and mask bit positions
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_TX_NEED = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_UNDERRUN = 3;
    localparam int ST_W = 4;

    // Scrambler seeds and feedback taps
    localparam logic [15:0] SEED_STD = 16'hffff;
    localparam logic [15:0] SEED_RESET = 16'hffff;
    localparam logic [15:0] SCR_TAPS = 16'hb400;
    localparam logic [3:0] BIT_LAST = 4'hf;

    // Seed choice carried in the frame head format byte
    typedef enum logic [1:0] {
        SCR_STD = 2'b00,
        SCR_A = 2'b01,
        SCR_B = 2'b10,
        SCR_NONE = 2'b11
    } msd_scr_e;

    // Data block formats
    localparam logic [2:0] FMT_RAW = 3'h0;
    localparam logic [2:0] FMT_HEAD_ONLY = 3'h1;
    localparam logic [2:0] FMT_FEC_CRC = 3'h4;
    localparam logic [2:0] FMT_INTERLEAVE = 3'h5;

    // Four-byte transfer unit formats
    function automatic logic unit_is_long(input logic [2:0] fmt);
        return (fmt == FMT_HEAD_ONLY) || (fmt == FMT_FEC_CRC) || (fmt == FMT_INTERLEAVE);
    endfunction

    // Seed chosen by a two-bit scrambler code
    function automatic logic [15:0] seed_of(input logic [1:0] code, input logic [15:0] sa,
                                            input logic [15:0] sb);
        return (code == SCR_A) ? sa : (code == SCR_B) ? sb : SEED_STD;
    endfunction
endpackage

// ---- msd_seed_store.sv ----
// Storage for the two custom scrambler seeds, written a byte at a time.
// Assumes the caller decodes the four program words and drives one write strobe.
module msd_seed_store (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [7:0] wr_byte,
    output logic [15:0] custom_seed_a,
    output logic [15:0] custom_seed_b
);
    // Four program bytes, low byte of seed a first
    logic [7:0] mem_q [4];

    // Byte writes; reset restores the default seeds
    always_ff @(posedge mclk) begin
        if (reset) begin
            mem_q[0] <= msd_pkg::SEED_RESET[7:0];
            mem_q[1] <= msd_pkg::SEED_RESET[15:8];
            mem_q[2] <= msd_pkg::SEED_RESET[7:0];
            mem_q[3] <= msd_pkg::SEED_RESET[15:8];
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_byte;
        end
    end

    // Seeds straight from the stored bytes
    assign custom_seed_a = {mem_q[1], mem_q[0]};
    assign custom_seed_b = {mem_q[3], mem_q[2]};
endmodule // msd_seed_store

// ---- msd_scrambler.sv ----
// Additive 16-bit scrambler; the same module descrambles.
// Assumes load and step are never high together.
module msd_scrambler (
    input wire logic mclk,
    input wire logic reset,
    input wire logic load,
    input wire logic [15:0] seed,
    input wire logic step,
    input wire logic din,
    output logic dout,
    output logic [15:0] state
);
    // Shift register state
    logic [15:0] lfsr_q;
    // Feedback bit
    wire fb = ^(lfsr_q & msd_pkg::SCR_TAPS);

    // Reload on block start, advance once per bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            lfsr_q <= msd_pkg::SEED_STD;
        end else if (load) begin
            lfsr_q <= seed;
        end else if (step) begin
            lfsr_q <= {lfsr_q[14:0], fb};
        end
    end

    // All-zero state leaves the data untouched
    assign dout = din ^ lfsr_q[15];
    assign state = lfsr_q;
endmodule // msd_scrambler

// ---- msd_framer.sv ----
// Top of the data block scrambler and two-word host buffer, APB slave.
// Assumes link strobes are one-cycle pulses synchronous to mclk.
//
// Design decisions made here: the APB register port and the register addresses.
module msd_framer #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic modem_enable,
    output logic [1:0] head_scr_code,
    input wire logic tx_block_start,
    input wire logic tx_bit_req,
    output logic tx_bit,
    output logic tx_bit_valid,
    input wire logic rx_block_start,
    input wire logic [1:0] rx_head_scr_code,
    input wire logic [2:0] rx_head_format,
    input wire logic rx_bit_valid,
    input wire logic rx_bit
);
    // Elaboration check on address width
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end

    // Bus handshake registers
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    // Control, status and mask
    logic [msd_pkg::CTRL_W-1:0] ctrl_q;
    logic [msd_pkg::ST_W-1:0] status_q, status_d, mask_q;
    logic irq_q, modem_en_q;
    logic [1:0] head_code_q;
    // Transmit buffer and serialiser
    logic [15:0] tx_buf0_q, tx_buf1_q;
    logic tx_full_q, tx_active_q, tx_wsel_q, tx_bit_q, tx_valid_q;
    logic [3:0] tx_cnt_q;
    // Receive buffer and deserialiser
    logic [15:0] rx_buf0_q, rx_buf1_q, rx_sh_q;
    logic rx_active_q, rx_wsel_q;
    logic [3:0] rx_cnt_q;
    logic [1:0] rx_code_q;
    logic [2:0] rx_fmt_q;
    // Seeds and scrambler taps
    logic [15:0] custom_seed_a, custom_seed_b, tx_state, rx_state;
    logic tx_scr_out, rx_scr_out;

    // Bus phase decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready_q;
    wire [7:0] addr = paddr[7:0];
    wire hi_zero = (paddr >> 8) == '0;
    wire wr_acc = access && pwrite && !pslverr_q;
    wire rd_acc = access && !pwrite && !pslverr_q;

    // Register hits
    wire hit_ctrl = hi_zero && addr == msd_pkg::REG_CTRL;
    wire hit_status = hi_zero && addr == msd_pkg::REG_STATUS;
    wire hit_mask = hi_zero && addr == msd_pkg::REG_MASK;
    wire hit_tx0 = hi_zero && addr == msd_pkg::REG_TXDATA0;
    wire hit_tx1 = hi_zero && addr == msd_pkg::REG_TXDATA1;
    wire hit_rx0 = hi_zero && addr == msd_pkg::REG_RXDATA0;
    wire hit_rx1 = hi_zero && addr == msd_pkg::REG_RXDATA1;
    wire hit_head = hi_zero && addr == msd_pkg::REG_RXHEAD;
    wire hit_seed = hi_zero && addr >= msd_pkg::REG_SEED_WORD_FIRST
                    && addr <= msd_pkg::REG_SEED_WORD_LAST && addr[1:0] == msd_pkg::WORD_ALIGN;
    wire mapped = hit_ctrl || hit_status || hit_mask || hit_tx0 || hit_tx1 || hit_rx0 || hit_rx1
                  || hit_head || hit_seed;
    wire [1:0] seed_idx = addr[3:2];

    // Control fields
    wire [1:0] ctl_scr = ctrl_q[msd_pkg::CTRL_SCR_LSB +: 2];
    wire ctl_raw = ctrl_q[msd_pkg::CTRL_RAW_BIT];
    wire [2:0] ctl_fmt = ctrl_q[msd_pkg::CTRL_FMT_LSB +: 3];
    wire [15:0] seed_bytes = seed_idx[1] ? custom_seed_b : custom_seed_a;
    wire [7:0] seed_rd = seed_idx[0] ? seed_bytes[15:8] : seed_bytes[7:0];

    // Read data selection
    wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_q) :
                         hit_status ? 32'(status_q) :
                         hit_mask ? 32'(mask_q) :
                         hit_tx0 ? 32'(tx_buf0_q) :
                         hit_tx1 ? 32'(tx_buf1_q) :
                         hit_rx0 ? 32'(rx_buf0_q) :
                         hit_rx1 ? 32'(rx_buf1_q) :
                         hit_head ? 32'({rx_fmt_q, rx_code_q}) :
                         hit_seed ? 32'(seed_rd) : 32'h0000_0000;

    // One wait-free access: answer ready in the access phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q <= setup ? rd_mux : prdata_q;
        end
    end

    // Control and mask writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q <= msd_pkg::CTRL_RESET;
            mask_q <= '0;
        end else begin
            ctrl_q <= (wr_acc && hit_ctrl) ? pwdata[msd_pkg::CTRL_W-1:0] : ctrl_q;
            mask_q <= (wr_acc && hit_mask) ? pwdata[msd_pkg::ST_W-1:0] : mask_q;
        end
    end

    // Custom seed bytes
    msd_seed_store u_seeds (
        .mclk(mclk),
        .reset(reset),
        .wr_en(wr_acc && hit_seed),
        .wr_idx(seed_idx),
        .wr_byte(pwdata[7:0]),
        .custom_seed_a(custom_seed_a),
        .custom_seed_b(custom_seed_b)
    );

    // Transmit decode
    wire tx_go = tx_block_start && modem_en_q;
    wire tx_long = msd_pkg::unit_is_long(ctl_fmt);
    wire tx_has_data = ctl_fmt != msd_pkg::FMT_HEAD_ONLY;
    wire tx_bypass = ctl_scr == msd_pkg::SCR_NONE || (ctl_fmt == msd_pkg::FMT_RAW && ctl_raw);
    wire tx_shift = tx_bit_req && tx_active_q && tx_full_q;
    wire tx_unit_done = tx_shift && tx_cnt_q == msd_pkg::BIT_LAST && tx_wsel_q == tx_long;
    wire tx_raw_bit = tx_wsel_q ? tx_buf1_q[msd_pkg::BIT_LAST - tx_cnt_q]
                                : tx_buf0_q[msd_pkg::BIT_LAST - tx_cnt_q];
    wire tx_out = tx_bypass ? tx_raw_bit : tx_scr_out;
    wire tx_wr_last = wr_acc && (tx_long ? hit_tx1 : hit_tx0);
    wire tx_underrun = tx_bit_req && tx_active_q && !tx_full_q;

    // Transmit scrambler, seeded at each block start
    msd_scrambler u_tx_scr (
        .mclk(mclk),
        .reset(reset),
        .load(tx_go),
        .seed(msd_pkg::seed_of(ctl_scr, custom_seed_a, custom_seed_b)),
        .step(tx_shift && !tx_bypass),
        .din(tx_raw_bit),
        .dout(tx_scr_out),
        .state(tx_state)
    );

    // Transmit buffer words, refused while a unit is pending
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_buf0_q <= 16'h0000;
            tx_buf1_q <= 16'h0000;
        end else begin
            tx_buf0_q <= (wr_acc && hit_tx0 && !tx_full_q) ? pwdata[15:0] : tx_buf0_q;
            tx_buf1_q <= (wr_acc && hit_tx1 && !tx_full_q) ? pwdata[15:0] : tx_buf1_q;
        end
    end

    // Transmit serialiser, MSB first
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_active_q <= 1'b0;
            tx_full_q <= 1'b0;
            tx_cnt_q <= 4'h0;
            tx_wsel_q <= 1'b0;
        end else begin
            if (!modem_en_q) begin
                tx_active_q <= 1'b0;
            end else if (tx_go) begin
                tx_active_q <= tx_has_data;
            end
            if (tx_unit_done) begin
                tx_full_q <= 1'b0;
            end else if (tx_wr_last && !tx_full_q) begin
                tx_full_q <= 1'b1;
            end
            if (tx_go || tx_unit_done) begin
                tx_cnt_q <= 4'h0;
                tx_wsel_q <= 1'b0;
            end else if (tx_shift) begin
                tx_cnt_q <= tx_cnt_q + 4'h1;
                tx_wsel_q <= tx_wsel_q ^ (tx_cnt_q == msd_pkg::BIT_LAST);
            end
        end
    end

    // Transmit bit out
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_bit_q <= 1'b0;
            tx_valid_q <= 1'b0;
        end else begin
            tx_bit_q <= tx_shift ? tx_out : tx_bit_q;
            tx_valid_q <= tx_shift;
        end
    end

    // Receive decode
    wire rx_go = rx_block_start && modem_en_q;
    wire rx_long = msd_pkg::unit_is_long(rx_fmt_q);
    wire rx_bypass = rx_code_q == msd_pkg::SCR_NONE || (rx_fmt_q == msd_pkg::FMT_RAW && ctl_raw);
    wire rx_take = rx_bit_valid && rx_active_q;
    wire rx_plain = rx_bypass ? rx_bit : rx_scr_out;
    wire rx_word_done = rx_take && rx_cnt_q == msd_pkg::BIT_LAST;
    wire rx_unit_done = rx_word_done && rx_wsel_q == rx_long;
    wire [15:0] rx_word = {rx_sh_q[14:0], rx_plain};
    wire rx_rd_last = rd_acc && (rx_long ? hit_rx1 : hit_rx0);

    // Receive descrambler, seeded by the head's code
    msd_scrambler u_rx_scr (
        .mclk(mclk),
        .reset(reset),
        .load(rx_go),
        .seed(msd_pkg::seed_of(rx_head_scr_code, custom_seed_a, custom_seed_b)),
        .step(rx_take && !rx_bypass),
        .din(rx_bit),
        .dout(rx_scr_out),
        .state(rx_state)
    );

    // Receive head capture and deserialiser
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_active_q <= 1'b0;
            rx_code_q <= msd_pkg::SCR_STD;
            rx_fmt_q <= msd_pkg::FMT_RAW;
            rx_sh_q <= 16'h0000;
            rx_cnt_q <= 4'h0;
            rx_wsel_q <= 1'b0;
        end else begin
            if (!modem_en_q) begin
                rx_active_q <= 1'b0;
            end else if (rx_go) begin
                rx_active_q <= rx_head_format != msd_pkg::FMT_HEAD_ONLY;
                rx_code_q <= rx_head_scr_code;
                rx_fmt_q <= rx_head_format;
            end
            rx_sh_q <= rx_take ? rx_word : rx_sh_q;
            if (rx_go || rx_unit_done) begin
                rx_cnt_q <= 4'h0;
                rx_wsel_q <= 1'b0;
            end else if (rx_take) begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
                rx_wsel_q <= rx_wsel_q ^ (rx_cnt_q == msd_pkg::BIT_LAST);
            end
        end
    end

    // Receive buffer words
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_buf0_q <= 16'h0000;
            rx_buf1_q <= 16'h0000;
        end else begin
            rx_buf0_q <= (rx_word_done && !rx_wsel_q) ? rx_word : rx_buf0_q;
            rx_buf1_q <= (rx_word_done && rx_wsel_q) ? rx_word : rx_buf1_q;
        end
    end

    // Sticky events: set wins over write-one clear and access clear
    wire [msd_pkg::ST_W-1:0] ev_set, ev_clr;
    assign ev_set[msd_pkg::ST_RX_AVAIL] = rx_unit_done;
    assign ev_set[msd_pkg::ST_TX_NEED] = (tx_go && tx_has_data && !tx_full_q) || tx_unit_done;
    assign ev_set[msd_pkg::ST_OVERRUN] = rx_unit_done && status_q[msd_pkg::ST_RX_AVAIL] && !rx_rd_last;
    assign ev_set[msd_pkg::ST_UNDERRUN] = tx_underrun;
    assign ev_clr[msd_pkg::ST_RX_AVAIL] = rx_rd_last;
    assign ev_clr[msd_pkg::ST_TX_NEED] = tx_wr_last;
    assign ev_clr[msd_pkg::ST_OVERRUN] = 1'b0;
    assign ev_clr[msd_pkg::ST_UNDERRUN] = 1'b0;
    wire [msd_pkg::ST_W-1:0] w1c = (wr_acc && hit_status) ? pwdata[msd_pkg::ST_W-1:0] : '0;
    assign status_d = (status_q & ~(ev_clr | w1c)) | ev_set;

    // Status, interrupt and mode outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_q <= '0;
            irq_q <= 1'b0;
            modem_en_q <= 1'b0;
            head_code_q <= msd_pkg::SCR_STD;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
            modem_en_q <= !ctrl_q[msd_pkg::CTRL_SELCALL_BIT];
            head_code_q <= ctl_scr;
        end
    end

    // Output connections, all from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign modem_enable = modem_en_q;
    assign head_scr_code = head_code_q;
    assign tx_bit = tx_bit_q;
    assign tx_bit_valid = tx_valid_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_std_seed_load: assert property (tx_go && ctl_scr == msd_pkg::SCR_STD |=> tx_state == msd_pkg::SEED_STD)
        else $error("standard seed not loaded");
    a_custom_seed_b: assert property (rx_go && rx_head_scr_code == msd_pkg::SCR_B
        |=> rx_state == $past(custom_seed_b))
        else $error("custom seed b not loaded");
    a_zero_seed_clear: assert property (tx_shift && tx_state == 16'h0000 |=> tx_bit_q == $past(tx_raw_bit))
        else $error("zero seed altered data");
    a_raw_passes: assert property (tx_shift && ctl_fmt == msd_pkg::FMT_RAW && ctl_raw
        |=> tx_bit_q == $past(tx_raw_bit) && tx_valid_q)
        else $error("raw format data was scrambled");
    a_head_only_idle: assert property (tx_go && ctl_fmt == msd_pkg::FMT_HEAD_ONLY
        |=> !tx_active_q ##1 !status_q[msd_pkg::ST_TX_NEED] || $past(status_q[msd_pkg::ST_TX_NEED]))
        else $error("head only format requested data");
    a_selcall_off: assert property (ctrl_q[msd_pkg::CTRL_SELCALL_BIT] |=> !modem_enable ##1 !tx_active_q)
        else $error("modem active in selective call mode");
    a_rx_hold: assert property (status_q[msd_pkg::ST_RX_AVAIL] && !rx_rd_last && !w1c[msd_pkg::ST_RX_AVAIL]
        |=> status_q[msd_pkg::ST_RX_AVAIL])
        else $error("receive request dropped early");
    a_head_code: assert property (ctrl_q == $past(ctrl_q) |=> head_scr_code == $past(ctl_scr))
        else $error("head scrambler code wrong");
    a_tx_need_set: assert property (tx_unit_done |=> status_q[msd_pkg::ST_TX_NEED] ##1 irq
        || !mask_q[msd_pkg::ST_TX_NEED] || !status_q[msd_pkg::ST_TX_NEED])
        else $error("transmit request not raised");
    a_unit_size: assert property (tx_shift && tx_long && tx_cnt_q == msd_pkg::BIT_LAST && !tx_wsel_q
        |=> tx_full_q && tx_wsel_q)
        else $error("long unit ended after one word");

    c_tx_unit: cover property (tx_unit_done ##[1:40] tx_wr_last);
    c_rx_unit: cover property (rx_unit_done ##[1:40] rx_rd_last);
    c_overrun: cover property (ev_set[msd_pkg::ST_OVERRUN]);
endmodule // msd_framer

// ---- msd_link_model.sv ----
// Far-side modem link model: frame start pulses, bit strobes and rx bits.
// Assumes the block's clock; its tasks are called from the bench.
module msd_link_model (
    input wire logic mclk,
    output logic tx_block_start,
    output logic tx_bit_req,
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    output logic rx_block_start,
    output logic [1:0] rx_head_scr_code,
    output logic [2:0] rx_head_format,
    output logic rx_bit_valid,
    output logic rx_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels from time zero
    initial begin
        {tx_block_start, tx_bit_req, rx_block_start, rx_bit_valid, rx_bit} = 5'h0;
        rx_head_scr_code = 2'h0;
        rx_head_format = 3'h0;
    end
    // Head done, data block begins
    task automatic tx_start();
        @(posedge mclk) tx_block_start <= 1'b1;
        @(posedge mclk) tx_block_start <= 1'b0;
    endtask
    // Pull one word, top bit first; a missing answer reads as unknown
    task automatic tx_pull(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk) tx_bit_req <= 1'b1;
            @(posedge mclk) tx_bit_req <= 1'b0;
            @(negedge mclk) w[i] = (tx_bit_valid === 1'b1) ? tx_bit : 1'bx;
        end
    endtask
    // Head with seed code and format, then one word top bit first
    task automatic rx_send(input logic [1:0] c, input logic [2:0] f, input logic [15:0] w);
        @(posedge mclk) begin
            rx_block_start <= 1'b1;
            rx_head_scr_code <= c;
            rx_head_format <= f;
        end
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk);
            rx_block_start <= 1'b0;
            rx_bit_valid <= 1'b1;
            rx_bit <= w[i];
        end
        @(posedge mclk);
        rx_bit_valid <= 1'b0;
        rx_bit <= ~w[0]; // Released line shows the inverse of the last bit
    endtask
endmodule // msd_link_model

// ---- msd_data_scrambler_buffer_bench.sv ----
// Self-checking bench: APB host tasks, link model, scrambler reference.
// Assumes the APB slave answers each access in some cycles; the watchdog bounds any wait.
module msd_data_scrambler_buffer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, modem_enable, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [1:0] head_scr_code, rx_code;
    logic [2:0] rx_fmt;
    logic tbs, tbr, tb, tbv, rbs, rbv, rb;
    logic [15:0] w, w_std, seeds [4] = '{16'hffff, 16'h1234, 16'h0000, 16'h0000};
    int miscompares = 0, num_checks = 0;
    msd_framer dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .modem_enable(modem_enable), .head_scr_code(head_scr_code), .tx_block_start(tbs), .tx_bit_req(tbr),
        .tx_bit(tb), .tx_bit_valid(tbv), .rx_block_start(rbs), .rx_head_scr_code(rx_code),
        .rx_head_format(rx_fmt), .rx_bit_valid(rbv), .rx_bit(rb));
    msd_link_model lm (.mclk(mclk), .tx_block_start(tbs), .tx_bit_req(tbr), .tx_bit(tb), .tx_bit_valid(tbv),
        .rx_block_start(rbs), .rx_head_scr_code(rx_code), .rx_head_format(rx_fmt), .rx_bit_valid(rbv), .rx_bit(rb));
    // 125 MHz clock
    initial forever #4 mclk = ~mclk;
    // One APB transfer, holds the access until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Compare and count
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read a register and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), e, r);
    endtask
    // Additive reference scrambler, output from the top stage
    function automatic logic [15:0] scr(input logic [15:0] s, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) begin
            d[i] = d[i] ^ s[15];
            s = {s[14:0], ^(s & msd_pkg::SCR_TAPS)};
        end
        return d;
    endfunction
    // Reference scrambler state after one 16-bit word
    function automatic logic [15:0] adv(input logic [15:0] s);
        for (int i = 0; i < 16; i++) s = {s[14:0], ^(s & msd_pkg::SCR_TAPS)};
        return s;
    endfunction
    // Verdict, the only end of the run
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        cmp("modem_enable", 1, modem_enable);
        rd(msd_pkg::REG_CTRL, 0);
        rd(msd_pkg::REG_SEED_WORD_FIRST, 32'hff);
        rd(8'h3c, 0);
        cmp("pslverr", 1, err);
        apb(1, msd_pkg::REG_MASK, 32'h3);
        apb(1, 8'h20, 32'h34);
        apb(1, 8'h24, 32'h12);
        apb(1, 8'h28, 32'h00);
        apb(1, 8'h2c, 32'h00);
        rd(8'h24, 32'h12);
        // Every seed code, format 2, tx then rx loopback
        for (int c = 0; c < 4; c++) begin
            apb(1, msd_pkg::REG_CTRL, 32'h10 | c);
            apb(1, msd_pkg::REG_STATUS, 32'hf);
            cmp("head_scr_code", c, head_scr_code);
            lm.tx_start();
            repeat (3) @(posedge mclk);
            rd(msd_pkg::REG_STATUS, 2);
            cmp("irq", 1, irq);
            apb(1, msd_pkg::REG_TXDATA0, 32'h0f0f);
            rd(msd_pkg::REG_STATUS, 0);
            lm.tx_pull(w);
            cmp("tx word", (c == 3) ? 16'h0f0f : scr(seeds[c], 16'h0f0f), w);
            if (c == 0) w_std = w;
            lm.rx_send(c[1:0], 3'h2, w);
            rd(msd_pkg::REG_RXDATA0, 32'h0f0f);
            rd(msd_pkg::REG_RXHEAD, 32'h8 | c);
        end
        // Wrong seed does not recover the data; second unread unit overruns
        lm.rx_send(2'h1, 3'h2, w_std);
        lm.rx_send(2'h1, 3'h2, w_std);
        rd(msd_pkg::REG_STATUS, 32'h7);
        rd(msd_pkg::REG_RXDATA0, scr(16'h1234, w_std));
        // Four-byte unit, format 4
        apb(1, msd_pkg::REG_CTRL, 32'h20);
        apb(1, msd_pkg::REG_STATUS, 32'hf);
        lm.tx_start();
        apb(1, msd_pkg::REG_TXDATA0, 32'h5a5a);
        rd(msd_pkg::REG_STATUS, 2);
        apb(1, msd_pkg::REG_TXDATA1, 32'h3c3c);
        rd(msd_pkg::REG_STATUS, 0);
        lm.tx_pull(w);
        cmp("long word", scr(16'hffff, 16'h5a5a), w);
        lm.tx_pull(w);
        cmp("long word 1", scr(adv(16'hffff), 16'h3c3c), w);
        // Head only, no data requested
        apb(1, msd_pkg::REG_CTRL, 32'h08);
        apb(1, msd_pkg::REG_STATUS, 32'hf);
        lm.tx_start();
        repeat (3) @(posedge mclk);
        rd(msd_pkg::REG_STATUS, 0);
        // Raw format 0 ignores scrambler, with interrupt masked
        apb(1, msd_pkg::REG_MASK, 32'h0);
        apb(1, msd_pkg::REG_CTRL, 32'h4);
        lm.tx_start();
        repeat (3) @(posedge mclk);
        cmp("masked irq", 0, irq);
        apb(1, msd_pkg::REG_TXDATA0, 32'h1234);
        lm.tx_pull(w);
        cmp("raw word", 16'h1234, w);
        // Bit requests with no unit pending flag underrun
        lm.tx_pull(w);
        rd(msd_pkg::REG_STATUS, 32'ha);
        // Selective-call mode shuts this modem
        apb(1, msd_pkg::REG_CTRL, 32'h800);
        repeat (3) @(posedge mclk);
        cmp("modem_enable", 0, modem_enable);
        print_verdict();
    end
endmodule // msd_data_scrambler_buffer_bench
